// File: dv/pmc_props.sv
/* checker for pmc_top: bus answer and mode assertions.
   bound to pmc_top at the foot; sees its ports only. */
`timescale 1ns/1ns
`default_nettype none
module pmc_props
  import pmc_pkg::*;
#(
  parameter int unsigned WAIT_SHIFT = 0
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic avs_waitrequest_o,
  input wire logic sleep_exec_i,
  input wire logic wake_i,
  input wire logic cpu_clk_en_o,
  input wire logic cpu_halt_o,
  input wire logic ext_osc_en_o,
  input wire logic rtc_tick_o,
  input wire logic [PMC_NUM_PER-1:0] per_clk_en_o,
  input wire logic [5:0] mode_o
);
  // loose bound: twice the longest count plus slack
  localparam int SMAX = 2 * (131072 >> WAIT_SHIFT) + 2;
  logic [18:0] scnt_reg;
  logic [18:0] scnt_next;
  always_comb begin
    scnt_next = (mode_o == PMC_SETTLE) ? scnt_reg + 19'h00001 : 19'h00000;
  end
  always_ff @(posedge core_clk_i) begin
    scnt_reg <= rst_i ? 19'h00000 : scnt_next;
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // ****************************************
  // assertions
  // ****************************************
  AST_BUS_ANSWER: assert property ((avs_read_i || avs_write_i) &&
    avs_waitrequest_o |=> !avs_waitrequest_o) else $error("no answer");
  AST_BUS_PULSE: assert property (!avs_waitrequest_o |=>
    avs_waitrequest_o) else $error("long answer");
  AST_STBY_HALT: assert property (mode_o == PMC_STBY &&
    $past(mode_o) == PMC_STBY && $past(mode_o, 2) == PMC_STBY |->
    cpu_halt_o && !ext_osc_en_o && !cpu_clk_en_o && per_clk_en_o == '0)
    else $error("standby not halted");
  AST_SLEEP_CPU: assert property (mode_o == PMC_SLEEP &&
    $past(mode_o) == PMC_SLEEP |-> cpu_halt_o && !cpu_clk_en_o &&
    ext_osc_en_o) else $error("sleep outputs wrong");
  AST_SUBSLP_OSC: assert property (mode_o == PMC_SUBSLP &&
    $past(mode_o) == PMC_SUBSLP |-> cpu_halt_o && !ext_osc_en_o)
    else $error("subsleep oscillator on");
  AST_SLEEP_SEL: assert property (sleep_exec_i && mode_o == PMC_ACTIVE
    |=> mode_o inside {PMC_SLEEP, PMC_SUBSLP, PMC_STBY})
    else $error("sleep not entered");
  AST_WAKE_SLEEP: assert property (wake_i && mode_o == PMC_SLEEP |=>
    mode_o == PMC_ACTIVE) else $error("sleep wake wrong");
  AST_SETTLE_END: assert property (mode_o == PMC_SETTLE ##1
    mode_o != PMC_SETTLE |-> mode_o == PMC_ACTIVE)
    else $error("settle exit wrong");
  AST_SETTLE_MAX: assert property (scnt_reg <= SMAX)
    else $error("settle too long");
  AST_RTC_PULSE: assert property (rtc_tick_o |=> !rtc_tick_o [*8])
    else $error("tick too wide");
  cover property (mode_o == PMC_STBY);
  cover property (mode_o == PMC_SETTLE);
  cover property (rtc_tick_o);
endmodule : pmc_props
bind pmc_top pmc_props #(.WAIT_SHIFT(WAIT_SHIFT)) u_props (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o),
  .sleep_exec_i(sleep_exec_i), .wake_i(wake_i),
  .cpu_clk_en_o(cpu_clk_en_o), .cpu_halt_o(cpu_halt_o),
  .ext_osc_en_o(ext_osc_en_o), .rtc_tick_o(rtc_tick_o),
  .per_clk_en_o(per_clk_en_o), .mode_o(mode_o));
`default_nettype wire

// File: dv/pmc_top_tb.sv
/* self-checking bench for pmc_top over its Avalon slave.
   assumes WAIT_SHIFT 10; subclock made here, rising every 16 cycles. */
`timescale 1ns/1ns
`default_nettype none
module pmc_top_tb
  import pmc_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic slp = 1'b0;
  logic wak = 1'b0;
  logic sub = 1'b0;
  logic [4:0] adr = 5'h00;
  logic [31:0] wd = 32'h00000000;
  logic [4:0] sdiv = 5'h00;
  logic [31:0] rdat, d;
  logic wreq, cen, halt, osc, ext, rtc;
  logic [15:0] pen;
  logic [5:0] mode;
  int miscompares = 0;
  int samples_checked = 0;
  int c0, c1, ce, rt, n;
  // settle counts after the 10-bit shift, floor of one
  int nw[8] = '{8, 16, 32, 64, 128, 1, 1, 1};
  always #2 clk = ~clk;
  always @(posedge clk) begin
    sdiv <= sdiv + 5'h01;
    sub <= sdiv[3];
  end
  pmc_top #(.WAIT_SHIFT(10)) dut (.core_clk_i(clk), .rst_i(rst),
    .avs_read_i(rd), .avs_write_i(wr), .avs_address_i(adr),
    .avs_writedata_i(wd), .avs_byteenable_i(4'hF), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wreq), .sleep_exec_i(slp), .wake_i(wak),
    .subclk_i(sub), .cpu_clk_en_o(cen), .cpu_halt_o(halt),
    .ext_osc_en_o(osc), .clk_src_ext_o(ext), .rtc_tick_o(rtc),
    .per_clk_en_o(pen), .mode_o(mode));
  // ****************************************
  // tasks
  // ****************************************
  task automatic conclude();
    $display("miscompares=%0d samples_checked=%0d", miscompares,
      samples_checked);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : conclude
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic hang();
    miscompares++;
    $display("Error t=%0t wait ran out", $time);
    conclude();
  endtask : hang
  // request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [4:0] a,
      input logic [31:0] v);
    int k;
    k = 0;
    adr <= a;
    wd <= v;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge clk);
      k++;
    end while (wreq !== 1'b0 && k < 50);
    if (wreq !== 1'b0) hang();
    d = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic pulse(input logic s);
    slp <= s;
    wak <= !s;
    @(posedge clk);
    slp <= 1'b0;
    wak <= 1'b0;
    @(posedge clk);
  endtask : pulse
  task automatic wmode(input logic [5:0] m);
    int k;
    k = 0;
    while (mode !== m && k < 400) begin
      @(posedge clk);
      k++;
    end
    if (mode !== m) hang();
    repeat (2) @(posedge clk);
  endtask : wmode
  task automatic cnt(input int len);
    c0 = 0;
    c1 = 0;
    ce = 0;
    rt = 0;
    repeat (len) begin
      @(posedge clk);
      c0 += int'(pen[0]);
      c1 += int'(pen[1]);
      ce += int'(cen);
      rt += int'(rtc);
    end
  endtask : cnt
  // ****************************************
  // sequence
  // ****************************************
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      bus(1'b0, 5'(i * 4), 32'h0);
      check(d, (i == 6) ? 32'h01 : 32'h00);
    end
    bus(1'b1, 5'h00, 32'hFF);
    bus(1'b0, 5'h00, 32'h0);
    check(d, 32'hF0);
    bus(1'b1, 5'h18, 32'hFF);
    bus(1'b0, 5'h18, 32'h0);
    check(d, 32'h01);
    bus(1'b1, 5'h00, 32'h0);
    bus(1'b1, 5'h10, 32'h30);
    for (int s = 0; s < 5; s++) begin
      bus(1'b1, 5'h04, 32'(s));
      cnt(256);
      cnt(128);
      check(c0, 64 >> ((s == 0) ? 0 : s + 2));
      check(ce, 128 >> ((s == 0) ? 0 : s + 2));
    end
    bus(1'b1, 5'h04, 32'h0);
    cnt(128);
    check(c1, 8);
    bus(1'b1, 5'h08, 32'h02);
    cnt(128);
    check({c0[7:0], c1[7:0]}, 16'h4000);
    bus(1'b1, 5'h08, 32'h0);
    pulse(1'b1);
    wmode(PMC_SLEEP);
    cnt(128);
    check({halt, osc, cen, c0[7:0]}, 11'h640);
    pulse(1'b0);
    wmode(PMC_ACTIVE);
    // waits scaled down by the shift
    for (int s = 0; s < 8; s++) begin
      bus(1'b1, 5'h00, 32'h80 | 32'(s << 4));
      pulse(1'b1);
      wmode(PMC_STBY);
      cnt(2048);
      check({halt, osc, cen, c0[7:0], rt[7:0]}, 19'h40001);
      pulse(1'b0);
      n = 0;
      while (mode !== PMC_SETTLE && n < 50) begin
        @(posedge clk);
        n++;
      end
      if (mode !== PMC_SETTLE) hang();
      n = 0;
      while (mode === PMC_SETTLE && n < 400) begin
        @(posedge clk);
        n++;
      end
      if (n >= 400) hang();
      check(mode, PMC_ACTIVE);
      check(n >= nw[s] && n <= nw[s] + 2, 1);
    end
    bus(1'b1, 5'h00, 32'h0);
    bus(1'b1, 5'h04, 32'h20);
    wmode(PMC_SUBACT);
    check({halt, osc}, 2'b00);
    cnt(256);
    check({c0[7:0], ce[7:0]}, 16'h0808);
    pulse(1'b1);
    wmode(PMC_SUBSLP);
    cnt(2048);
    check({halt, osc, cen, rt[7:0]}, 11'h401);
    check(c0, 64);
    pulse(1'b0);
    wmode(PMC_SUBACT);
    bus(1'b1, 5'h04, 32'h0);
    wmode(PMC_ACTIVE);
    bus(1'b1, 5'h04, 32'h40);
    wmode(PMC_SETTLE);
    wmode(PMC_ACTIVE);
    check(ext, 1'b1);
    bus(1'b0, 5'h18, 32'h0);
    check(d, 32'h81);
    bus(1'b1, 5'h04, 32'h0);
    repeat (2) @(posedge clk);
    check(ext, 1'b0);
    conclude();
  end
endmodule : pmc_top_tb
`default_nettype wire

// File: rtl/pmc_pkg.sv
/*
 * Package for the prescaler and power-mode controller: register map,
 * field positions, reset values, mode encodings, carrier structs.
 * Assumes a single 250 MHz core clock and a synchronous reset.
 */
// Summary of operation
// R1: a 13-bit system prescaler counts on the system clock for peripherals
// R2: reset clears the system prescaler; it counts once reset is released
// R3: standby and subsleep stop the oscillator and hold the prescaler at zero
// R4: the system prescaler count is never readable or writable by software
// R5: each peripheral picks its own prescaler tap independently
// R6: in active and sleep, prescaler input is divided by the 3-bit ratio field
// R7: a 5-bit watch prescaler counts subclock divided by four for the RTC
// R8: reset clears the watch prescaler; it counts once reset ends
// R9: watch prescaler keeps counting in standby, subactive and subsleep
// R10: active mode runs on oscillator clock divided by 1, 8, 16, 32 or 64
// R11: subactive mode runs on the watch clock divided by 2, 4 or 8
// R12: sleep and subsleep halt the CPU; peripherals keep their clock
// R13: standby halts CPU and peripherals; only the RTC time base runs
// R14: each unused peripheral can be halted alone by module halt bits
// R15: on sleep, standby select 0 gives sleep or subsleep, 1 gives standby
// R16: wait select bits 6..4 set the settling wait leaving low-power modes
// R17: the same wait select times the switch to the external clock
// R18: software programs at least 6.5 ms for resonators, 100 us external
// R19: the settling wait lies between the programmed count and twice it
// R20: peripheral clocks are one-cycle enables from a prescaler bit rising
package pmc_pkg;

  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [4:0] PMC_OFF_WAIT_CTRL = 5'h00;
  localparam logic [4:0] PMC_OFF_MODE_TWO = 5'h04;
  localparam logic [4:0] PMC_OFF_HALT_ONE = 5'h08;
  localparam logic [4:0] PMC_OFF_HALT_TWO = 5'h0C;
  localparam logic [4:0] PMC_OFF_TAP_LO = 5'h10;
  localparam logic [4:0] PMC_OFF_TAP_HI = 5'h14;
  localparam logic [4:0] PMC_OFF_STATUS = 5'h18;

  // ****************************************
  // fields and reset values
  // ****************************************
  localparam int PMC_STANDBY_SELECT_BIT = 7;
  localparam int PMC_STS_LSB = 4;
  localparam int PMC_DIV_LSB = 0;
  localparam int PMC_SUB_LSB = 3;
  localparam int PMC_LSPD_BIT = 5;
  localparam int PMC_EXT_BIT = 6;
  localparam int PMC_NUM_PER = 16;
  localparam int PMC_PS_W = 13;
  localparam int PMC_WPS_W = 5;
  localparam int PMC_WAIT_W = 18;
  localparam logic [7:0] PMC_RST_WAIT_CTRL = 8'h00;
  localparam logic [7:0] PMC_RST_MODE_TWO = 8'h00;
  localparam logic [7:0] PMC_RST_HALT = 8'h00;
  localparam logic [31:0] PMC_RST_TAP = 32'h00000000;
  localparam logic [3:0] PMC_TAP_MAX = 4'hC;

  // ****************************************
  // modes
  // ****************************************
  typedef enum logic [5:0] {
    PMC_ACTIVE = 6'h01,
    PMC_SLEEP = 6'h02,
    PMC_SUBACT = 6'h04,
    PMC_SUBSLP = 6'h08,
    PMC_STBY = 6'h10,
    PMC_SETTLE = 6'h20
  } pmc_mode_t;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic read;
    logic write;
    logic [4:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } pmc_avm_req_t;

  typedef struct packed {
    logic waitrequest;
    logic [31:0] readdata;
  } pmc_avm_rsp_t;

  typedef struct packed {
    logic cpu_clk_en;
    logic cpu_halt;
    logic ext_osc_en;
    logic clk_src_ext;
    logic rtc_tick;
    logic [PMC_NUM_PER-1:0] per_clk_en;
    pmc_mode_t mode;
  } pmc_clk_out_t;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [PMC_WAIT_W-1:0] pmc_wait_states(
      input logic [2:0] sel);
    case (sel)
      3'h0: pmc_wait_states = 18'h02000;
      3'h1: pmc_wait_states = 18'h04000;
      3'h2: pmc_wait_states = 18'h08000;
      3'h3: pmc_wait_states = 18'h10000;
      3'h4: pmc_wait_states = 18'h20000;
      3'h5: pmc_wait_states = 18'h00400;
      3'h6: pmc_wait_states = 18'h00080;
      default: pmc_wait_states = 18'h00010;
    endcase
  endfunction : pmc_wait_states

  function automatic logic [31:0] pmc_merge(input logic [31:0] old,
      input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    pmc_merge = r;
  endfunction : pmc_merge

endpackage : pmc_pkg

// File: rtl/pmc_sync3.sv
/*
 * Three-flop synchroniser for the subclock pin with rising-edge pulse.
 * Assumes the pin toggles far slower than the core clock.
 */
`timescale 1ns/1ns
`default_nettype none
module pmc_sync3
  import pmc_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic pin_i,
  output logic rise_o
);

  typedef struct packed {
    logic [2:0] ff;
    logic level;
    logic rise;
  } pmc_sync_st_t;

  pmc_sync_st_t s_reg;
  pmc_sync_st_t s_next;

  // ****************************************
  // filter
  // ****************************************
  always_comb begin
    s_next = s_reg;
    s_next.ff = {s_reg.ff[1:0], pin_i};
    s_next.rise = 1'b0;
    // stage 1 feeds stage 2 only; stages 2 and 3 must agree
    if (s_reg.ff[1] == s_reg.ff[2]) begin
      s_next.level = s_reg.ff[2];
      s_next.rise = s_reg.ff[2] & ~s_reg.level;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rise_o = s_reg.rise;

endmodule : pmc_sync3
`default_nettype wire

// File: rtl/pmc_top.sv
/*
 * Prescaler and power-mode controller: system and watch prescalers,
 * six-mode power controller, per-peripheral clock enables, Avalon-MM
 * register slave with waitrequest.
 * Assumes sleep and wake requests come from core-clock logic, and the
 * subclock arrives asynchronously on a pin.
 */
// Decided for this implementation: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module pmc_top
  import pmc_pkg::*;
#(
  parameter int unsigned WAIT_SHIFT = 0
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [4:0] avs_address_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic sleep_exec_i,
  input wire logic wake_i,
  input wire logic subclk_i,
  output logic cpu_clk_en_o,
  output logic cpu_halt_o,
  output logic ext_osc_en_o,
  output logic clk_src_ext_o,
  output logic rtc_tick_o,
  output logic [PMC_NUM_PER-1:0] per_clk_en_o,
  output logic [5:0] mode_o
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic standby_select;
    logic [2:0] sts;
    logic [2:0] div_sel;
    logic [1:0] sub_sel;
    logic low_spd;
    logic ext_req;
    logic ext_src;
    logic [PMC_NUM_PER-1:0] halt;
    logic [63:0] tap;
    logic [5:0] div_cnt;
    logic [PMC_PS_W-1:0] ps;
    logic [2:0] sub_cnt;
    logic [1:0] wdiv;
    logic [PMC_WPS_W-1:0] wps;
    logic settle_start;
    pmc_avm_rsp_t rsp;
    pmc_clk_out_t out;
  } pmc_top_st_t;

  pmc_top_st_t s_reg;
  pmc_top_st_t s_next;
  pmc_avm_req_t req;
  logic sub_rise;
  logic wait_done;
  logic sys_tick;
  logic sub_tick;
  logic ps_run;
  logic per_run;
  logic [PMC_PS_W-1:0] ps_new;
  logic [PMC_NUM_PER-1:0] tap_rise;
  logic [31:0] rd_mux;
  logic [31:0] wait_word;
  logic [31:0] mode_word;
  logic [31:0] status_word;

  assign req = '{read: avs_read_i, write: avs_write_i,
                 address: avs_address_i, writedata: avs_writedata_i,
                 byteenable: avs_byteenable_i};

  // ****************************************
  // leaf blocks
  // ****************************************
  pmc_sync3 u_sub_sync (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .pin_i(subclk_i),
    .rise_o(sub_rise)
  );

  pmc_wait_timer #(
    .WAIT_SHIFT(WAIT_SHIFT)
  ) u_wait (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .start_i(s_reg.settle_start),
    .sel_i(s_reg.sts),
    .done_o(wait_done)
  );

  // ****************************************
  // rate enables
  // ****************************************
  always_comb begin
    // R10 oscillator divided by 1, 8, 16, 32, 64
    case (s_reg.div_sel)
      3'h0: sys_tick = 1'b1;
      3'h1: sys_tick = &s_reg.div_cnt[2:0];
      3'h2: sys_tick = &s_reg.div_cnt[3:0];
      3'h3: sys_tick = &s_reg.div_cnt[4:0];
      default: sys_tick = &s_reg.div_cnt[5:0];
    endcase
    // R11 watch clock divided by 2, 4, 8
    case (s_reg.sub_sel)
      2'h0: sub_tick = sub_rise & s_reg.sub_cnt[0];
      2'h1: sub_tick = sub_rise & (&s_reg.sub_cnt[1:0]);
      default: sub_tick = sub_rise & (&s_reg.sub_cnt[2:0]);
    endcase
  end

  // R3 oscillator-fed modes only
  assign ps_run = (s_reg.out.mode == PMC_ACTIVE) |
                  (s_reg.out.mode == PMC_SLEEP) |
                  (s_reg.out.mode == PMC_SETTLE);
  // R13 peripherals stop in standby
  assign per_run = (s_reg.out.mode != PMC_STBY);
  // R1 count on the divided system clock
  assign ps_new = (ps_run && sys_tick) ? s_reg.ps + 13'h0001 : s_reg.ps;

  // ****************************************
  // per-peripheral enables
  // ****************************************
  genvar gp;
  generate
    for (gp = 0; gp < PMC_NUM_PER; gp++) begin : g_per
      logic [3:0] t;
      assign t = (s_reg.tap[gp*4 +: 4] > PMC_TAP_MAX) ? PMC_TAP_MAX :
                 s_reg.tap[gp*4 +: 4];
      // R5 independent tap per peripheral
      // R20 pulse on tap bit rising
      assign tap_rise[gp] = ps_run & sys_tick & ps_new[t] & ~s_reg.ps[t];
    end
  endgenerate

  // ****************************************
  // register read words
  // ****************************************
  assign wait_word = {24'h000000, s_reg.standby_select, s_reg.sts, 4'h0};
  assign mode_word = {25'h0000000, s_reg.ext_req, s_reg.low_spd,
                      s_reg.sub_sel, s_reg.div_sel};
  // R4 prescaler count kept off the bus
  assign status_word = {24'h000000, s_reg.out.clk_src_ext,
                        s_reg.settle_start | (s_reg.out.mode == PMC_SETTLE),
                        s_reg.out.mode};

  always_comb begin
    case (req.address)
      PMC_OFF_WAIT_CTRL: rd_mux = wait_word;
      PMC_OFF_MODE_TWO: rd_mux = mode_word;
      PMC_OFF_HALT_ONE: rd_mux = {24'h000000, s_reg.halt[7:0]};
      PMC_OFF_HALT_TWO: rd_mux = {24'h000000, s_reg.halt[15:8]};
      PMC_OFF_TAP_LO: rd_mux = s_reg.tap[31:0];
      PMC_OFF_TAP_HI: rd_mux = s_reg.tap[63:32];
      PMC_OFF_STATUS: rd_mux = status_word;
      default: rd_mux = 32'h00000000;
    endcase
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic [31:0] w;
    logic wr_now;
    w = 32'h00000000;
    wr_now = 1'b0;
    s_next = s_reg;
    s_next.settle_start = 1'b0;

    // bus: one wait state, then waitrequest low for one cycle
    s_next.rsp.waitrequest = 1'b1;
    if ((req.read || req.write) && s_reg.rsp.waitrequest) begin
      s_next.rsp.waitrequest = 1'b0;
      s_next.rsp.readdata = req.read ? rd_mux : 32'h00000000;
      wr_now = req.write;
    end
    if (wr_now) begin
      case (req.address)
        PMC_OFF_WAIT_CTRL: begin
          w = pmc_merge(wait_word, req.writedata, req.byteenable);
          s_next.standby_select = w[PMC_STANDBY_SELECT_BIT];
          s_next.sts = w[PMC_STS_LSB +: 3];
        end
        PMC_OFF_MODE_TWO: begin
          w = pmc_merge(mode_word, req.writedata, req.byteenable);
          s_next.div_sel = w[PMC_DIV_LSB +: 3];
          s_next.sub_sel = w[PMC_SUB_LSB +: 2];
          s_next.low_spd = w[PMC_LSPD_BIT];
          s_next.ext_req = w[PMC_EXT_BIT];
          // dropping the request falls straight back to on-chip clock
          if (!w[PMC_EXT_BIT]) begin
            s_next.ext_src = 1'b0;
          end
        end
        // R14 module halt bits
        PMC_OFF_HALT_ONE: begin
          if (req.byteenable[0]) begin
            s_next.halt[7:0] = req.writedata[7:0];
          end
        end
        PMC_OFF_HALT_TWO: begin
          if (req.byteenable[0]) begin
            s_next.halt[15:8] = req.writedata[7:0];
          end
        end
        PMC_OFF_TAP_LO: begin
          s_next.tap[31:0] = pmc_merge(s_reg.tap[31:0], req.writedata,
                                       req.byteenable);
        end
        PMC_OFF_TAP_HI: begin
          s_next.tap[63:32] = pmc_merge(s_reg.tap[63:32], req.writedata,
                                        req.byteenable);
        end
        default: begin
          w = 32'h00000000;
        end
      endcase
    end

    // R6 ratio divider feeding prescaler
    s_next.div_cnt = ps_run ? s_reg.div_cnt + 6'h01 : 6'h00;
    // R2 R3 cleared whenever the oscillator is stopped
    s_next.ps = ps_run ? ps_new : '0;

    if (sub_rise) begin
      s_next.sub_cnt = s_reg.sub_cnt + 3'h1;
    end
    // R7 R9 watch prescaler on subclock divided by four, every mode
    s_next.out.rtc_tick = 1'b0;
    if (sub_rise) begin
      s_next.wdiv = s_reg.wdiv + 2'h1;
      if (s_reg.wdiv == 2'h3) begin
        s_next.wps = s_reg.wps + 5'h01;
        s_next.out.rtc_tick = &s_reg.wps;
      end
    end

    // ****************************************
    // mode controller
    // ****************************************
    case (s_reg.out.mode)
      PMC_ACTIVE: begin
        if (sleep_exec_i) begin
          // R15 standby select chooses target
          if (s_reg.standby_select) begin
            s_next.out.mode = PMC_STBY;
          end else if (s_reg.low_spd) begin
            s_next.out.mode = PMC_SUBSLP;
          end else begin
            s_next.out.mode = PMC_SLEEP;
          end
        end else if (s_reg.low_spd) begin
          s_next.out.mode = PMC_SUBACT;
        end else if (s_reg.ext_req && !s_reg.ext_src) begin
          // R17 switch to external clock waits too
          s_next.out.mode = PMC_SETTLE;
          s_next.settle_start = 1'b1;
        end
      end
      PMC_SLEEP: begin
        if (wake_i) begin
          s_next.out.mode = PMC_ACTIVE;
        end
      end
      PMC_SUBACT: begin
        if (sleep_exec_i) begin
          s_next.out.mode = s_reg.standby_select ? PMC_STBY : PMC_SUBSLP;
        end else if (!s_reg.low_spd) begin
          // R16 settle before oscillator-clocked modes
          s_next.out.mode = PMC_SETTLE;
          s_next.settle_start = 1'b1;
        end
      end
      PMC_SUBSLP, PMC_STBY: begin
        if (wake_i) begin
          if (s_reg.low_spd) begin
            s_next.out.mode = PMC_SUBACT;
          end else begin
            // R16 settling wait on exit
            s_next.out.mode = PMC_SETTLE;
            s_next.settle_start = 1'b1;
          end
        end
      end
      PMC_SETTLE: begin
        // R16 on-chip clock until count expires
        if (wait_done) begin
          s_next.out.mode = PMC_ACTIVE;
          // a request dropped at this edge must not latch the external clock
          s_next.ext_src = s_reg.ext_req & s_next.ext_req;
        end
      end
      default: begin
        s_next.out.mode = PMC_ACTIVE;
      end
    endcase

    // ****************************************
    // clock outputs
    // ****************************************
    // R12 CPU halted outside active, subactive and settling
    s_next.out.cpu_halt = !((s_reg.out.mode == PMC_ACTIVE) ||
                            (s_reg.out.mode == PMC_SUBACT) ||
                            (s_reg.out.mode == PMC_SETTLE));
    s_next.out.cpu_clk_en = 1'b0;
    if ((s_reg.out.mode == PMC_ACTIVE) || (s_reg.out.mode == PMC_SETTLE)) begin
      s_next.out.cpu_clk_en = sys_tick;
    end else if (s_reg.out.mode == PMC_SUBACT) begin
      s_next.out.cpu_clk_en = sub_tick;
    end
    // R3 oscillator off in standby and subsleep
    s_next.out.ext_osc_en = ps_run;
    s_next.out.clk_src_ext = s_reg.ext_src &&
                             ((s_reg.out.mode == PMC_ACTIVE) ||
                              (s_reg.out.mode == PMC_SLEEP));
    // R12 R14 peripherals gated per module
    if (ps_run) begin
      s_next.out.per_clk_en = tap_rise & ~s_reg.halt;
    end else if (per_run) begin
      s_next.out.per_clk_en = {PMC_NUM_PER{sub_tick}} & ~s_reg.halt;
    end else begin
      s_next.out.per_clk_en = '0;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge core_clk_i) begin
    // R2 R8 both prescalers cleared by reset
    if (rst_i) begin
      s_reg <= '0;
      s_reg.standby_select <= PMC_RST_WAIT_CTRL[PMC_STANDBY_SELECT_BIT];
      s_reg.sts <= PMC_RST_WAIT_CTRL[PMC_STS_LSB +: 3];
      s_reg.div_sel <= PMC_RST_MODE_TWO[PMC_DIV_LSB +: 3];
      s_reg.sub_sel <= PMC_RST_MODE_TWO[PMC_SUB_LSB +: 2];
      s_reg.halt <= {PMC_RST_HALT, PMC_RST_HALT};
      s_reg.tap <= {PMC_RST_TAP, PMC_RST_TAP};
      s_reg.rsp.waitrequest <= 1'b1;
      s_reg.out.mode <= PMC_ACTIVE;
      s_reg.out.ext_osc_en <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign avs_readdata_o = s_reg.rsp.readdata;
  assign avs_waitrequest_o = s_reg.rsp.waitrequest;
  assign cpu_clk_en_o = s_reg.out.cpu_clk_en;
  assign cpu_halt_o = s_reg.out.cpu_halt;
  assign ext_osc_en_o = s_reg.out.ext_osc_en;
  assign clk_src_ext_o = s_reg.out.clk_src_ext;
  assign rtc_tick_o = s_reg.out.rtc_tick;
  assign per_clk_en_o = s_reg.out.per_clk_en;
  assign mode_o = s_reg.out.mode;

endmodule : pmc_top
`default_nettype wire

// File: rtl/pmc_wait_timer.sv
/*
 * Oscillator settling wait counter, timed in on-chip oscillator states.
 * Assumes start is a one-cycle pulse from the mode controller.
 */
`timescale 1ns/1ns
`default_nettype none
module pmc_wait_timer
  import pmc_pkg::*;
#(
  parameter int unsigned WAIT_SHIFT = 0
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic [2:0] sel_i,
  output logic done_o
);

  typedef struct packed {
    logic busy;
    logic [PMC_WAIT_W-1:0] cnt;
    logic done;
  } pmc_wait_st_t;

  pmc_wait_st_t s_reg;
  pmc_wait_st_t s_next;
  logic [PMC_WAIT_W-1:0] load;

  always_comb begin
    load = pmc_wait_states(sel_i) >> WAIT_SHIFT;
    if (load == '0) begin
      load = 18'h00001;
    end
    s_next = s_reg;
    s_next.done = 1'b0;
    // R19 exact programmed count
    if (start_i) begin
      s_next.busy = 1'b1;
      s_next.cnt = load - 18'h00001;
    end else if (s_reg.busy) begin
      if (s_reg.cnt == '0) begin
        s_next.busy = 1'b0;
        s_next.done = 1'b1;
      end else begin
        s_next.cnt = s_reg.cnt - 18'h00001;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign done_o = s_reg.done;

endmodule : pmc_wait_timer
`default_nettype wire
